/* File: hw/display_defs.svh */
// Constants for the status display sequencer
`ifndef DISPLAY_DEFS_SVH
`define DISPLAY_DEFS_SVH
`define CLK_MHZ       64'd100
`define MS_CYCLES(ms) (64'(ms) * 64'd1000 * `CLK_MHZ)
`define DWELL_MS      1500
`define RECOVER_MS    10000
`define FIELD_FREE_MS 5000
`define TEXT_MS       40000
`define SCROLL_MS     250
`define TEXT_MAX      6'd32
`define REC_INDEX     16'h70DD
`define REC_SUBSLOT   16'h0001
`define REC_SLOT_HI   16'h0001
`define CHAR_LO       8'h20
`define CHAR_HI       8'h7E
`define CHAR_SUB      8'h3F
`define LETTER_F      8'h46
`define LETTER_E      8'h45
`define LETTER_U      8'h55
`define LETTER_I      8'h49
`define LETTER_P      8'h50
`define BOOT_LEN_CFG  4'h9
`define BOOT_LEN_NONE 4'h8
`endif

/* File: hw/display_pkg.sv */
// Types shared by the status display sequencer
`include "display_defs.svh"
package display_pkg;
  typedef enum logic [4:0] {
    scr_sensor_type, scr_sw_version, scr_serial, scr_net_name, scr_addr_mode,
    scr_wireless, scr_cfg_date, scr_signature, scr_align, scr_config_missing_banner,
    scr_config_wait_banner, scr_config_transfer_banner, scr_ping, scr_diag,
    scr_locked, scr_message, scr_text, scr_normal
  } screen_type;
  typedef enum logic [2:0] {cat_failure, cat_external, cat_usage, cat_info, cat_param} diag_cat_type;
  typedef enum logic [3:0] {
    mode_boot, mode_idle, mode_cfg_wait, mode_cfg_xfer, mode_ping,
    mode_diag, mode_message, mode_text, mode_locked
  } mode_type;
  typedef struct packed {
    logic [15:0] slot;
    logic [15:0] subslot;
    logic [15:0] index;
  } record_addr_type;
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } text_beat_type;
  typedef struct packed {
    diag_cat_type cat;
    logic [11:0]  code;
    logic         locking;
  } diag_type;
  typedef struct packed {
    logic [3:0]  source;
    logic [11:0] code;
  } message_type;
  typedef struct packed {
    screen_type  screen;
    logic        blank;
    logic        rotate;
    logic [7:0]  letter;
    logic [11:0] code;
    logic [3:0]  source;
    logic [7:0]  field_pair;
    logic [5:0]  text_len;
    logic [4:0]  scroll_pos;
  } display_type;
  function automatic logic [7:0] cat_letter(input diag_cat_type c);
    unique case (c)
      cat_failure:  cat_letter = `LETTER_F;
      cat_external: cat_letter = `LETTER_E;
      cat_usage:    cat_letter = `LETTER_U;
      cat_info:     cat_letter = `LETTER_I;
      cat_param:    cat_letter = `LETTER_P;
      default:      cat_letter = `LETTER_F;
    endcase
  endfunction
endpackage

/* File: hw/status_display_sequencer.sv */
// Status display sequencer: screen selection, diagnostics, recovery and scrolling text
`timescale 1ns/1ps
`include "display_defs.svh"
module status_display_sequencer #(
  parameter logic [31:0] DWELL_CYCLES   = 32'(`MS_CYCLES(`DWELL_MS)),
  parameter logic [31:0] RECOVER_CYCLES = 32'(`MS_CYCLES(`RECOVER_MS)),
  parameter logic [31:0] FREE_CYCLES    = 32'(`MS_CYCLES(`FIELD_FREE_MS)),
  parameter logic [31:0] TEXT_CYCLES    = 32'(`MS_CYCLES(`TEXT_MS)),
  parameter logic [31:0] SCROLL_CYCLES  = 32'(`MS_CYCLES(`SCROLL_MS))
) (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  input  wire logic                        boot_active,
  input  wire logic                        config_present,
  input  wire logic                        cfg_wait,
  input  wire logic                        cfg_transfer,
  input  wire logic                        ping_event,
  input  wire logic                        diag_event,
  input  display_pkg::diag_type            diag_in,
  input  wire logic                        msg_event,
  input  display_pkg::message_type         msg_in,
  input  wire logic                        field_free,
  input  wire logic [7:0]                  field_pair,
  input  wire logic                        blank_cfg,
  input  wire logic                        rotate_cfg,
  input  display_pkg::record_addr_type     rec_addr,
  input  display_pkg::text_beat_type       text_beat,
  input  wire logic [4:0]                  text_rd_addr,
  output display_pkg::display_type         disp,
  output logic [7:0]                       text_rd_data,
  output logic                             automatic_error_recovery
);
  import display_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [7:0]  text_mem [32];
  logic        capture;
  logic [5:0]  wptr;
  logic [5:0]  text_len;
  logic        next_capture;
  logic [5:0]  next_wptr;
  logic [5:0]  next_text_len;
  logic        text_we;
  logic [4:0]  text_waddr;
  logic [7:0]  text_wdata;
  logic        text_done;
  logic        addr_ok;
  logic [5:0]  wpos;

  mode_type    mode;
  logic [31:0] tmr;
  logic [3:0]  idx;
  logic [31:0] stmr;
  logic [4:0]  scroll_pos;
  diag_type    diag;
  message_type msg;
  mode_type    next_mode;
  logic [31:0] next_tmr;
  logic [3:0]  next_idx;
  logic [31:0] next_stmr;
  logic [4:0]  next_scroll_pos;
  diag_type    next_diag;
  message_type next_msg;
  logic        next_recovery;
  display_type next_disp;
  logic        busy_diag;

  function automatic screen_type boot_screen(input logic [3:0] i, input logic cfg);
    if (!cfg && i == 4'h6) begin
      boot_screen = scr_config_missing_banner;
    end else if (!cfg && i == 4'h7) begin
      boot_screen = scr_align;
    end else begin
      boot_screen = screen_type'({1'b0, i});
    end
  endfunction

  // Text capture from the record write
  always_comb begin
    addr_ok = (rec_addr.slot <= `REC_SLOT_HI) && (rec_addr.subslot == `REC_SUBSLOT)
              && (rec_addr.index == `REC_INDEX);
    wpos          = text_beat.first ? 6'h00 : wptr;
    next_capture  = capture;
    next_wptr     = wptr;
    next_text_len = text_len;
    text_we       = 1'b0;
    text_waddr    = wpos[4:0];
    text_done     = 1'b0;
    if (text_beat.data < `CHAR_LO || text_beat.data > `CHAR_HI) begin
      text_wdata = `CHAR_SUB;
    end else begin
      text_wdata = text_beat.data;
    end
    if (text_beat.valid) begin
      if (text_beat.first) begin
        next_capture = addr_ok;
        next_wptr    = 6'h00;
      end
      if (text_beat.first ? addr_ok : capture) begin
        if (wpos != `TEXT_MAX) begin
          text_we   = 1'b1;
          next_wptr = wpos + 6'h01;
        end
        if (text_beat.last) begin
          text_done     = 1'b1;
          next_capture  = 1'b0;
          next_text_len = (wpos != `TEXT_MAX) ? wpos + 6'h01 : `TEXT_MAX;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture  <= 1'b0;
      wptr     <= 6'h00;
      text_len <= 6'h00;
    end else begin
      capture  <= next_capture;
      wptr     <= next_wptr;
      text_len <= next_text_len;
    end
  end

  always_ff @(posedge core_clk) begin
    if (text_we) begin
      text_mem[text_waddr] <= text_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      text_rd_data <= 8'h00;
    end else begin
      text_rd_data <= text_mem[text_rd_addr];
    end
  end

  // Mode sequencing and screen selection
  always_comb begin
    next_mode       = mode;
    next_tmr        = tmr;
    next_idx        = idx;
    next_stmr       = stmr;
    next_scroll_pos = scroll_pos;
    next_diag       = diag;
    next_msg        = msg;
    next_recovery   = 1'b0;
    busy_diag       = (mode == mode_diag);
    if (mode == mode_locked) begin
      next_mode = mode_locked;
    end else if (diag_event && diag_in.locking) begin
      next_mode = mode_locked;
      next_diag = diag_in;
    end else if (boot_active) begin
      next_mode = mode_boot;
      if (mode != mode_boot) begin
        next_idx = 4'h0;
        next_tmr = 32'h0;
      end else if (tmr == DWELL_CYCLES - 32'h1) begin
        next_tmr = 32'h0;
        next_idx = (idx + 4'h1 == (config_present ? `BOOT_LEN_CFG : `BOOT_LEN_NONE))
                   ? 4'h0 : idx + 4'h1;
      end else begin
        next_tmr = tmr + 32'h1;
      end
    end else if (cfg_transfer) begin
      next_mode = mode_cfg_xfer;
    end else if (cfg_wait) begin
      next_mode = mode_cfg_wait;
    end else if (diag_event) begin
      next_mode = mode_diag;
      next_diag = diag_in;
      next_tmr  = 32'h0;
    end else if (ping_event && !busy_diag) begin
      next_mode = mode_ping;
      next_tmr  = 32'h0;
    end else if (msg_event && !busy_diag) begin
      next_mode = mode_message;
      next_msg  = msg_in;
      next_tmr  = 32'h0;
    end else if (text_done && !busy_diag) begin
      next_mode       = mode_text;
      next_tmr        = 32'h0;
      next_stmr       = 32'h0;
      next_scroll_pos = 5'h00;
    end else begin
      unique case (mode)
        mode_diag: begin
          next_tmr = tmr + 32'h1;
          if (tmr == RECOVER_CYCLES - 32'h1) begin
            next_recovery = 1'b1;
            next_mode     = mode_idle;
            next_tmr      = 32'h0;
          end
        end
        mode_ping: begin
          next_tmr = tmr + 32'h1;
          if (tmr == DWELL_CYCLES - 32'h1) begin
            next_mode = mode_idle;
            next_tmr  = 32'h0;
          end
        end
        mode_message: begin
          next_tmr = field_free ? tmr + 32'h1 : 32'h0;
          if (field_free && tmr == FREE_CYCLES - 32'h1) begin
            next_mode = mode_idle;
            next_tmr  = 32'h0;
          end
        end
        mode_text: begin
          next_tmr  = tmr + 32'h1;
          next_stmr = stmr + 32'h1;
          if (stmr == SCROLL_CYCLES - 32'h1) begin
            next_stmr       = 32'h0;
            next_scroll_pos = ({1'b0, scroll_pos} + 6'h01 >= text_len) ? 5'h00 : scroll_pos + 5'h01;
          end
          if (tmr == TEXT_CYCLES - 32'h1) begin
            next_mode = mode_idle;
            next_tmr  = 32'h0;
          end
        end
        mode_idle: begin
          next_mode = mode_idle;
        end
        default: begin
          next_mode = mode_idle;
          next_tmr  = 32'h0;
        end
      endcase
    end

    next_disp            = disp;
    next_disp.blank      = blank_cfg;
    next_disp.rotate     = rotate_cfg;
    next_disp.field_pair = field_pair;
    next_disp.letter     = cat_letter(next_diag.cat);
    next_disp.code       = (next_mode == mode_message) ? next_msg.code : next_diag.code;
    next_disp.source     = next_msg.source;
    next_disp.text_len   = text_len;
    next_disp.scroll_pos = next_scroll_pos;
    unique case (next_mode)
      mode_boot:     next_disp.screen = boot_screen(next_idx, config_present);
      mode_idle:     next_disp.screen = config_present ? scr_normal : scr_align;
      mode_cfg_wait: next_disp.screen = scr_config_wait_banner;
      mode_cfg_xfer: next_disp.screen = scr_config_transfer_banner;
      mode_ping:     next_disp.screen = scr_ping;
      mode_diag:     next_disp.screen = scr_diag;
      mode_message:  next_disp.screen = scr_message;
      mode_text:     next_disp.screen = scr_text;
      mode_locked:   next_disp.screen = scr_locked;
      default:       next_disp.screen = scr_locked;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode                     <= mode_boot;
      tmr                      <= 32'h0;
      idx                      <= 4'h0;
      stmr                     <= 32'h0;
      scroll_pos               <= 5'h00;
      diag                     <= '0;
      msg                      <= '0;
      automatic_error_recovery <= 1'b0;
      disp                     <= '0;
    end else begin
      mode                     <= next_mode;
      tmr                      <= next_tmr;
      idx                      <= next_idx;
      stmr                     <= next_stmr;
      scroll_pos               <= next_scroll_pos;
      diag                     <= next_diag;
      msg                      <= next_msg;
      automatic_error_recovery <= next_recovery;
      disp                     <= next_disp;
    end
  end

  // Checks
  sequence s_diag_raised;
    diag_event && !diag_in.locking && mode != mode_locked && !boot_active && !cfg_transfer && !cfg_wait;
  endsequence
  sequence s_diag_shown;
    mode == mode_diag && disp.screen == scr_diag;
  endsequence

  chk_boot_start: assert property ((mode == mode_boot && $past(mode) != mode_boot)
    |-> disp.screen == scr_sensor_type) else $error("boot does not open on sensor type");
  chk_boot_step: assert property ((mode == mode_boot && $past(mode) == mode_boot && idx != $past(idx))
    |-> $past(tmr) == DWELL_CYCLES - 32'h1) else $error("boot screen stepped early");
  chk_xfer_banner: assert property ((mode != mode_locked && !boot_active && cfg_transfer && !diag_event)
    |=> disp.screen == scr_config_transfer_banner) else $error("transfer banner missing");
  chk_ping_shown: assert property ((mode == mode_idle && ping_event && !boot_active && !cfg_wait
    && !cfg_transfer && !diag_event) |=> disp.screen == scr_ping) else $error("ping screen missing");
  chk_diag_entry: assert property (s_diag_raised |=> s_diag_shown)
    else $error("diagnostic not shown");
  chk_diag_letter: assert property (mode == mode_diag |-> disp.letter == cat_letter(diag.cat)
    && disp.code == diag.code) else $error("diagnostic letter or code wrong");
  chk_recover_time: assert property (automatic_error_recovery |-> $past(mode) == mode_diag
    && $past(tmr) == RECOVER_CYCLES - 32'h1 && mode == mode_idle) else $error("recovery timing wrong");
  chk_locked_hold: assert property (mode == mode_locked |=> mode == mode_locked && !automatic_error_recovery)
    else $error("locked state left");
  chk_msg_return: assert property ((mode == mode_message && !field_free && !diag_event && !ping_event)
    |=> mode != mode_idle) else $error("message left while field occupied");
  chk_blank_follow: assert property (##1 (disp.blank == $past(blank_cfg) && disp.rotate == $past(rotate_cfg)))
    else $error("blank or rotate not applied");
  chk_text_limit: assert property (text_len <= `TEXT_MAX && (!text_we || wpos < `TEXT_MAX))
    else $error("text beyond limit");
  chk_text_slot: assert property ((text_beat.valid && text_beat.first && !addr_ok) |=> !capture)
    else $error("text taken from wrong record");
  chk_text_clean: assert property (text_we |-> text_wdata >= `CHAR_LO && text_wdata <= `CHAR_HI)
    else $error("unsupported character stored");
  chk_msg_source: assert property (mode == mode_message |-> disp.source == msg.source
    && disp.code == msg.code) else $error("message source or code wrong");
  chk_field_pair: assert property (disp.screen == scr_normal |-> disp.field_pair == $past(field_pair))
    else $error("field pair not shown");
endmodule

/* File: verif/controller_model.sv */
// Safety controller model issuing acyclic text record writes
`timescale 1ns/1ps
module controller_model (
  input  wire logic                    core_clk,
  output display_pkg::record_addr_type rec_addr,
  output display_pkg::text_beat_type   text_beat
);
  import display_pkg::*;
  initial begin
    rec_addr  = '0;
    text_beat = '0;
  end
  // One record, one byte per cycle, then released to inverted values
  task automatic send(input logic [15:0] slot, input logic [15:0] sub, input logic [15:0] idx,
                      input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge core_clk);
      #1;
      rec_addr  = '{slot, sub, idx};
      text_beat = '{1'b1, i == 0, i == b.size() - 1, b[i]};
    end
    @(posedge core_clk);
    #1;
    rec_addr  = ~rec_addr;
    text_beat = '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
  endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench of the status display sequencer
`timescale 1ns/1ps
module tb_top;
  import display_pkg::*;
  localparam int DW = 8;
  localparam int RC = 20;
  localparam int FR = 10;
  localparam int TX = 40;
  localparam int SC = 4;
  logic            core_clk = 0, arst_n = 0, boot_active = 0, config_present = 1;
  logic            cfg_wait = 0, cfg_transfer = 0, ping_event = 0, diag_event = 0;
  logic            msg_event = 0, field_free = 1, blank_cfg = 0, rotate_cfg = 0;
  logic [7:0]      field_pair = 8'h5A;
  logic [4:0]      text_rd_addr = 5'h00;
  diag_type        diag_in = '0;
  message_type     msg_in = '0;
  record_addr_type rec_addr;
  text_beat_type   text_beat;
  display_type     disp;
  logic [7:0]      text_rd_data;
  logic            automatic_error_recovery;
  logic [7:0]      lt [5] = '{8'h46, 8'h45, 8'h55, 8'h49, 8'h50};
  int              error_cnt = 0, samples_checked = 0;

  always #5 core_clk = ~core_clk;

  controller_model u_ctrl (.core_clk(core_clk), .rec_addr(rec_addr), .text_beat(text_beat));

  status_display_sequencer #(.DWELL_CYCLES(32'(DW)), .RECOVER_CYCLES(32'(RC)), .FREE_CYCLES(32'(FR)),
    .TEXT_CYCLES(32'(TX)), .SCROLL_CYCLES(32'(SC))) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .boot_active(boot_active), .config_present(config_present),
    .cfg_wait(cfg_wait), .cfg_transfer(cfg_transfer), .ping_event(ping_event), .diag_event(diag_event),
    .diag_in(diag_in), .msg_event(msg_event), .msg_in(msg_in), .field_free(field_free),
    .field_pair(field_pair), .blank_cfg(blank_cfg), .rotate_cfg(rotate_cfg), .rec_addr(rec_addr),
    .text_beat(text_beat), .text_rd_addr(text_rd_addr), .disp(disp), .text_rd_data(text_rd_data),
    .automatic_error_recovery(automatic_error_recovery));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    arst_n = 0;
    tick(2);
    arst_n = 1;
  endtask

  task automatic wait_scr(input screen_type s, input int lim, output int n);
    n = 0;
    while (disp.screen !== s && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    text_rd_addr = a;
    tick(1);
    chk("text buffer", exp, text_rd_data);
  endtask

  task automatic t_boot(input logic cfg);
    logic [4:0] seen[$];
    logic [4:0] exp[$];
    int         n;
    if (cfg) exp = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 0};
    else exp = '{0, 1, 2, 3, 4, 5, 9, 8, 0};
    config_present = cfg;
    boot_active = 1;
    do_reset();
    seen.push_back(disp.screen);
    repeat (exp.size() * DW + 2) begin
      tick(1);
      if (disp.screen !== seen[$]) seen.push_back(disp.screen);
    end
    for (int i = 0; i < exp.size(); i++) chk("boot screen", exp[i], seen[i]);
    boot_active = 0;
    wait_scr(cfg ? scr_normal : scr_align, 4, n);
    chk("after boot", cfg ? scr_normal : scr_align, disp.screen);
    if (cfg) chk("field pair", 8'h5A, disp.field_pair);
  endtask

  task automatic t_cfg();
    cfg_wait = 1;
    tick(2);
    chk("awaiting", scr_config_wait_banner, disp.screen);
    cfg_transfer = 1;
    tick(2);
    chk("transfer", scr_config_transfer_banner, disp.screen);
    cfg_transfer = 0;
    cfg_wait = 0;
    tick(2);
    chk("cfg done", scr_normal, disp.screen);
  endtask

  task automatic t_ping();
    int n;
    ping_event = 1;
    tick(1);
    ping_event = 0;
    wait_scr(scr_ping, 3, n);
    chk("ping screen", scr_ping, disp.screen);
    wait_scr(scr_normal, DW + 5, n);
    chk("ping dwell", 1, n >= DW - 2 && n <= DW + 2);
  endtask

  task automatic t_diag(input diag_cat_type c, input logic lock);
    int n;
    diag_in = '{cat: c, code: 12'h120 + 12'(c), locking: lock};
    diag_event = 1;
    tick(1);
    diag_event = 0;
    chk("diag screen", lock ? scr_locked : scr_diag, disp.screen);
    if (!lock) chk("diag letter", lt[c], disp.letter);
    if (!lock) chk("diag code", 12'h120 + 12'(c), disp.code);
    n = 1;
    ping_event = 1;
    while (automatic_error_recovery !== 1'b1 && n < RC + 5) begin
      tick(1);
      ping_event = 0;
      n++;
    end
    chk("recovery delay", lock ? RC + 5 : RC + 1, n);
    tick(1);
    chk("after diag", lock ? scr_locked : scr_normal, disp.screen);
  endtask

  task automatic t_msg();
    int n;
    field_free = 0;
    msg_in = '{4'h3, 12'hE12};
    msg_event = 1;
    tick(1);
    msg_event = 0;
    wait_scr(scr_message, 3, n);
    chk("msg source", 4'h3, disp.source);
    chk("msg code", 12'hE12, disp.code);
    tick(3 * FR);
    chk("msg held", scr_message, disp.screen);
    field_free = 1;
    wait_scr(scr_normal, FR + 5, n);
    chk("free delay", 1, n >= FR - 2 && n <= FR + 2);
  endtask

  task automatic t_bits();
    blank_cfg = 1;
    rotate_cfg = 1;
    tick(2);
    chk("blank", 1, disp.blank);
    chk("rotate", 1, disp.rotate);
    blank_cfg = 0;
    rotate_cfg = 0;
    tick(2);
    chk("unblank", 0, {disp.blank, disp.rotate});
  endtask

  task automatic t_text();
    logic [7:0] b[$];
    logic [4:0] p;
    int         n;
    u_ctrl.send(16'h0000, 16'h0001, 16'h70DD, '{8'h41, 8'h42, 8'h43});
    wait_scr(scr_text, 3, n);
    tick(1);
    chk("text len", 3, disp.text_len);
    p = disp.scroll_pos;
    tick(SC + 1);
    chk("scrolling", 1, p !== disp.scroll_pos);
    u_ctrl.send(16'h0000, 16'h0001, 16'h70DC, '{8'h5A});
    u_ctrl.send(16'h0001, 16'h0002, 16'h70DD, '{8'h5A});
    u_ctrl.send(16'h0002, 16'h0001, 16'h70DD, '{8'h5A});
    chk("bad record", 3, disp.text_len);
    rd(5'h00, 8'h41);
    for (int i = 0; i < 34; i++) b.push_back(8'h61 + 8'(i % 26));
    b[2] = 8'h01;
    b[3] = 8'h7F;
    u_ctrl.send(16'h0001, 16'h0001, 16'h70DD, b);
    wait_scr(scr_text, 3, n);
    tick(1);
    chk("long len", 32, disp.text_len);
    rd(5'h02, 8'h3F);
    rd(5'h03, 8'h3F);
    rd(5'h1F, 8'h66);
    wait_scr(scr_normal, TX + 5, n);
    chk("text shown", 1, n + 4 >= TX - 3 && n + 4 <= TX + 3);
  endtask

  task automatic test_done();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    int n;
    t_boot(1'b0);
    t_boot(1'b1);
    t_cfg();
    t_ping();
    for (int c = 0; c < 5; c++) t_diag(diag_cat_type'(c), 1'b0);
    t_diag(cat_external, 1'b1);
    do_reset();
    wait_scr(scr_normal, 4, n);
    chk("power cycle", scr_normal, disp.screen);
    t_msg();
    t_text();
    t_bits();
    test_done();
  end

  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
